// ==== src/alert_status_defines.svh ====
// Offsets, field positions and reset values for the channel 0-3 alert status register
`ifndef ALERT_STATUS_DEFINES_SVH
`define ALERT_STATUS_DEFINES_SVH

`define ALERT_STATUS_ADDR   16'h0015
`define ALERT_FLAGS_RESET   8'h00
`define ALERT_LO_BIT_OFS    1
`define ALERT_HI_BIT_OFS    0
`define DEV_STATUS_SUM_BIT  3

`endif

// ==== src/alert_status_pkg.sv ====
// Types shared by the alert status register and its limit comparator
`default_nettype none
package alert_status_pkg;

  // One conversion result as it leaves the converter core
  typedef struct packed {
    logic        valid;
    logic [2:0]  channel;
    logic [15:0] result;
  } conv_t;

  // Per-channel programmed limits and hysteresis band width
  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] band;
  } limits_t;

  // Comparator verdicts for one result
  typedef struct packed {
    logic hi_hit;
    logic lo_hit;
    logic hi_release;
    logic lo_release;
  } verdict_t;

  // Register read request from the serial register interface
  typedef struct packed {
    logic        rd_en;
    logic [15:0] addr;
  } reg_rd_t;

  // Whole state of the alert status block
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       summary;
  } alert_state_t;

endpackage
`default_nettype wire

// ==== src/limit_compare.sv ====
// Threshold and hysteresis comparisons for a single conversion result
`default_nettype none
module limit_compare (
  input  wire  logic [15:0]                result,
  input  wire  alert_status_pkg::limits_t  limits,
  output var   alert_status_pkg::verdict_t verdict
);
  import alert_status_pkg::*;

  // Zero-extend so that limit plus band cannot wrap
  function automatic logic [16:0] widen(input logic [15:0] v);
    widen = {1'b0, v};
  endfunction

  // Hit on equality too; release only strictly beyond the band
  always_comb begin
    verdict.hi_hit     = result >= limits.upper;
    verdict.lo_hit     = result <= limits.lower;
    verdict.hi_release = (widen(result) + widen(limits.band)) < widen(limits.upper);
    verdict.lo_release = widen(result) > (widen(limits.lower) + widen(limits.band));
  end

endmodule
`default_nettype wire

// ==== src/alert_status_ch0_3.sv ====
// Upper and lower alert status flags for channels 0 to 3, cleared on read
`include "alert_status_defines.svh"
`default_nettype none
module alert_status_ch0_3 (
  input  wire  logic                            clk_sys,
  input  wire  logic                            reset,
  input  wire  alert_status_pkg::conv_t         conv,
  input  wire  alert_status_pkg::limits_t [3:0] ch_limits,
  input  wire  logic [3:0]                      detect_en,
  input  wire  logic                            alert_mode,
  input  wire  logic [7:0]                      ch4_7_flags,
  input  wire  alert_status_pkg::reg_rd_t       reg_rd,
  output logic [7:0]                            rd_data_q,
  output logic                                  rd_valid_q,
  output logic [7:0]                            alert_flags_q,
  output logic                                  any_limit_summary_bit_q
);
  import alert_status_pkg::*;

  alert_state_t st_q;
  alert_state_t st_d;
  verdict_t     verdict;
  logic [1:0]   sel;
  logic         take;
  logic         rd_hit;
  logic [7:0]   set_v;
  logic [7:0]   rel_v;
  logic [7:0]   clr_v;

  // Flag position of a channel's lower or upper indicator
  function automatic logic [2:0] flag_pos(input logic [1:0] ch, input logic lower);
    flag_pos = {ch, lower};
  endfunction

  // Channel field of the result selects which limits apply
  assign sel    = conv.channel[1:0];
  assign rd_hit = reg_rd.rd_en && (reg_rd.addr == `ALERT_STATUS_ADDR);
  // Results for channels 4-7 belong to the second status register
  assign take   = conv.valid && !conv.channel[2] && detect_en[sel];

  // One comparator serves all four channels: at most one result arrives per cycle
  limit_compare limit_compare_i (
    .result  (conv.result),
    .limits  (ch_limits[sel]),
    .verdict (verdict)
  );

  // Next state: clears first, then sets, so a fresh alert always survives
  always_comb begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;
    set_v         = '0;
    rel_v         = '0;
    clr_v         = '0;
    if (take) begin
      set_v[flag_pos(sel, 1'b1)] = verdict.lo_hit;
      set_v[flag_pos(sel, 1'b0)] = verdict.hi_hit;
      if (alert_mode) begin
        rel_v[flag_pos(sel, 1'b1)] = verdict.lo_release;
        rel_v[flag_pos(sel, 1'b0)] = verdict.hi_release;
      end
    end
    clr_v = rel_v;
    // A read captures the old flags and wipes them in the same edge
    if (rd_hit) begin
      st_d.rd_data  = st_q.flags;
      st_d.rd_valid = 1'b1;
      clr_v         = 8'hff;
    end
    st_d.flags   = (st_q.flags & ~clr_v) | set_v;
    // Not sticky: follows the flags, so it drops as soon as they clear
    st_d.summary = (|st_d.flags) || (|ch4_7_flags);
  end

  // Single state register, constants only under reset
  // Fields are cleared one by one so that none is forgotten when the state grows
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q.flags    <= `ALERT_FLAGS_RESET;
      st_q.rd_data  <= 8'h00;
      st_q.rd_valid <= 1'b0;
      st_q.summary  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign rd_data_q               = st_q.rd_data;
  assign rd_valid_q              = st_q.rd_valid;
  assign alert_flags_q           = st_q.flags;
  assign any_limit_summary_bit_q = st_q.summary;

  // Checks on the flag behaviour
  logic [2:0] lo_pos;
  logic [2:0] hi_pos;
  assign lo_pos = flag_pos(sel, 1'b1);
  assign hi_pos = flag_pos(sel, 1'b0);
  // Both flag bits of the channel that the current result belongs to
  logic [7:0] ch_mask;
  assign ch_mask = 8'h03 << {sel, 1'b0};

  sequence s_lo_event;
    take && verdict.lo_hit;
  endsequence

  sequence s_hi_event;
    take && verdict.hi_hit;
  endsequence

  property p_lo_set;
    @(posedge clk_sys) disable iff (reset)
    s_lo_event |=> st_q.flags[$past(lo_pos)];
  endproperty
  a_lo_set: assert property (p_lo_set) else $error("lower flag not set");

  property p_hi_set;
    @(posedge clk_sys) disable iff (reset)
    s_hi_event |=> st_q.flags[$past(hi_pos)];
  endproperty
  a_hi_set: assert property (p_hi_set) else $error("upper flag not set");

  property p_no_set_disabled;
    @(posedge clk_sys) disable iff (reset)
    (st_q.flags & ~$past(st_q.flags)) != 8'h00 |-> $past(take);
  endproperty
  a_no_set_disabled: assert property (p_no_set_disabled)
    else $error("flag rose without enabled result");

  property p_read_old;
    @(posedge clk_sys) disable iff (reset)
    rd_hit |=> rd_valid_q && (rd_data_q == $past(st_q.flags));
  endproperty
  a_read_old: assert property (p_read_old) else $error("read did not return held flags");

  property p_read_clear;
    @(posedge clk_sys) disable iff (reset)
    rd_hit && !take |=> st_q.flags == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

  property p_auto_clear;
    @(posedge clk_sys) disable iff (reset)
    ($past(st_q.flags) & ~st_q.flags) != 8'h00 |->
      $past(rd_hit) || ($past(alert_mode) && $past(take));
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("flag cleared without cause");

  property p_release;
    @(posedge clk_sys) disable iff (reset)
    take && alert_mode && verdict.hi_release && !rd_hit |=> !st_q.flags[$past(hi_pos)];
  endproperty
  a_release: assert property (p_release) else $error("in-band result kept upper flag");

  property p_reset_zero;
    @(posedge clk_sys) disable iff (reset)
    $past(reset) |-> st_q.flags == `ALERT_FLAGS_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

  property p_summary;
    @(posedge clk_sys) disable iff (reset)
    ##1 any_limit_summary_bit_q == ((|st_q.flags) || (|$past(ch4_7_flags)));
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit mismatch");

  property p_mapping;
    @(posedge clk_sys) disable iff (reset)
    take && verdict.lo_hit && !verdict.hi_hit && !st_q.flags[hi_pos] && !rd_hit
      |=> !st_q.flags[$past(hi_pos)];
  endproperty
  a_mapping: assert property (p_mapping) else $error("lower event touched upper bit");

  // Other channels keep their bits whatever this result does
  property p_own_channel;
    @(posedge clk_sys) disable iff (reset)
    take && !rd_hit |=> ((st_q.flags ^ $past(st_q.flags)) & ~$past(ch_mask)) == 8'h00;
  endproperty
  a_own_channel: assert property (p_own_channel) else $error("other channel touched");

  // Every flag change traces back to an accepted result or a read
  property p_quiet;
    @(posedge clk_sys) disable iff (reset)
    !take && !rd_hit |=> st_q.flags == $past(st_q.flags);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flags moved without result or read");

  // The read answer is a single pulse that only a read can raise
  property p_valid_pulse;
    @(posedge clk_sys) disable iff (reset)
    !rd_hit |=> !rd_valid_q;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("read valid without read");

  // Read data holds between reads so a slow host can still pick it up
  property p_data_hold;
    @(posedge clk_sys) disable iff (reset)
    !rd_hit |=> $stable(rd_data_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data changed without read");

  // Lower flag release mirrors the upper one, just above the lower limit plus band
  sequence s_lo_release;
    take && alert_mode && verdict.lo_release && !rd_hit;
  endsequence

  property p_lo_release;
    @(posedge clk_sys) disable iff (reset)
    s_lo_release |=> !st_q.flags[$past(lo_pos)];
  endproperty
  a_lo_release: assert property (p_lo_release) else $error("lower flag kept in band");

endmodule
`default_nettype wire

// ==== test/alert_host_model.sv ====
// Host model that issues register reads and conversion results
`default_nettype none
module alert_host_model (
  input  wire logic                      clk_sys,
  output var  alert_status_pkg::reg_rd_t reg_rd,
  output var  alert_status_pkg::conv_t   conv
);
  timeunit 1ns;
  timeprecision 1ps;
  import alert_status_pkg::*;

  // Quiet bus at time zero
  initial begin
    reg_rd = '0;
    conv   = '0;
  end

  // One read pulse; afterwards the address points elsewhere so a stale hit cannot recur
  task automatic read(input logic [15:0] addr);
    @(posedge clk_sys);
    reg_rd <= '{rd_en: 1'b1, addr: addr};
    @(posedge clk_sys);
    reg_rd <= '{rd_en: 1'b0, addr: 16'hffff};
  endtask

  // One result; the released lines show the inverse, not the old value
  task automatic convert(input logic [2:0] ch, input logic [15:0] value);
    @(posedge clk_sys);
    conv <= '{valid: 1'b1, channel: ch, result: value};
    @(posedge clk_sys);
    conv <= '{valid: 1'b0, channel: ~ch, result: ~value};
  endtask
endmodule
`default_nettype wire

// ==== test/alert_status_ch0_3_tb.sv ====
// Self-checking bench for the channel 0-3 alert status register
`default_nettype none
module alert_status_ch0_3_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alert_status_pkg::*;
  logic             clk_sys     = 1'b0;
  logic             reset       = 1'b1;
  logic [3:0]       detect_en   = 4'hf;
  logic             alert_mode  = 1'b0;
  logic [7:0]       ch4_7_flags = 8'h00;
  limits_t [3:0]    ch_limits   = {4{limits_t'{16'hc000, 16'h4000, 16'h0100}}};
  reg_rd_t          reg_rd;
  conv_t            conv;
  logic [7:0]       rd_data_q, alert_flags_q, exp;
  logic             rd_valid_q, any_limit_summary_bit_q;
  int               fail_count  = 0;
  int               check_count = 0;

  initial forever #4 clk_sys = ~clk_sys;

  alert_host_model alert_host_model_i (.clk_sys(clk_sys), .reg_rd(reg_rd), .conv(conv));
  alert_status_ch0_3 alert_status_ch0_3_i (
    .clk_sys(clk_sys), .reset(reset), .conv(conv), .ch_limits(ch_limits),
    .detect_en(detect_en), .alert_mode(alert_mode), .ch4_7_flags(ch4_7_flags),
    .reg_rd(reg_rd), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .alert_flags_q(alert_flags_q), .any_limit_summary_bit_q(any_limit_summary_bit_q));

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  // Read, then look at the answer in the cycle it stands
  task automatic rd(input logic [15:0] a, input logic hit, input logic [7:0] e);
    alert_host_model_i.read(a);
    #1;
    chk("rd_valid_q", {7'h0, hit}, {7'h0, rd_valid_q});
    if (hit) chk("rd_data_q", e, rd_data_q);
  endtask

  // Summary check assumes the channel 4-7 flags are quiet
  task automatic cv(input logic [2:0] ch, input logic [15:0] v, input logic [7:0] e);
    alert_host_model_i.convert(ch, v);
    #1;
    chk("alert_flags_q", e, alert_flags_q);
    chk("summary", {7'h0, |e}, {7'h0, any_limit_summary_bit_q});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    #1 chk("alert_flags_q", 8'h00, alert_flags_q);
    chk("summary", 8'h00, {7'h0, any_limit_summary_bit_q});
    chk("rd_valid_q", 8'h00, {7'h0, rd_valid_q});
    rd(16'h0015, 1'b1, 8'h00);
    $display("test reset done");
    cv(3'd0, 16'hbfff, 8'h00);
    cv(3'd0, 16'h4001, 8'h00);
    exp = 8'h00;
    for (int c = 0; c < 4; c++) begin
      exp[2*c] = 1'b1;
      cv(3'(c), 16'hc000, exp);
      exp[2*c+1] = 1'b1;
      cv(3'(c), 16'h4000, exp);
    end
    $display("test limits done");
    rd(16'h0016, 1'b0, 8'h00);
    rd(16'h0015, 1'b1, 8'hff);
    chk("alert_flags_q", 8'h00, alert_flags_q);
    rd(16'h0015, 1'b1, 8'h00);
    $display("test read clear done");
    @(posedge clk_sys) detect_en <= 4'he;
    cv(3'd0, 16'hffff, 8'h00);
    cv(3'd4, 16'h0000, 8'h00);
    @(posedge clk_sys) detect_en <= 4'hf;
    @(posedge clk_sys) ch4_7_flags <= 8'h10;
    repeat (2) @(posedge clk_sys);
    #1 chk("summary", 8'h01, {7'h0, any_limit_summary_bit_q});
    @(posedge clk_sys) ch4_7_flags <= 8'h00;
    $display("test enable and summary done");
    // Band edges: one code inside the band must not clear
    @(posedge clk_sys) alert_mode <= 1'b1;
    cv(3'd1, 16'hc000, 8'h04);
    cv(3'd1, 16'hbf00, 8'h04);
    cv(3'd1, 16'hbeff, 8'h00);
    cv(3'd1, 16'h4000, 8'h08);
    cv(3'd1, 16'h4100, 8'h08);
    cv(3'd1, 16'h4101, 8'h00);
    $display("test hysteresis done");
    cv(3'd2, 16'hc000, 8'h10);
    fork
      alert_host_model_i.read(16'h0015);
      alert_host_model_i.convert(3'd3, 16'h4000);
    join
    #1 chk("rd_data_q", 8'h10, rd_data_q);
    chk("alert_flags_q", 8'h80, alert_flags_q);
    $display("test set priority done");
    report_and_stop();
  end

  // The sequence needs about 70 cycles; a hang is cut well beyond that
  initial begin
    repeat (2000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
